/* hw/fdcr_pkg.sv */
// Package for the floppy configuration register bank: offsets, fields, resets
package fdcr_pkg;

  // ==========================================================================
  // Register indices; the bus byte address is the index times four
  // ==========================================================================
  localparam logic [7:0] IDX_MODE = 8'hF0;
  localparam logic [7:0] IDX_OPTION = 8'hF1;
  localparam logic [7:0] IDX_TYPE = 8'hF2;
  localparam logic [7:0] IDX_RSVD = 8'hF3;
  localparam logic [7:0] IDX_DRV0 = 8'hF4;
  localparam logic [7:0] IDX_DRV1 = 8'hF5;
  localparam logic [7:0] IDX_SOFT_RESET = 8'hF6;
  localparam logic [7:0] IDX_STATUS = 8'hF7;
  localparam int ADDR_W = 10;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_MODE = 8'h0E;
  localparam logic [7:0] RST_OPTION = 8'h00;
  localparam logic [7:0] RST_TYPE = 8'hFF;
  localparam logic [7:0] RST_DRV = 8'h00;

  // ==========================================================================
  // Writable masks; other bits read as zero
  // ==========================================================================
  localparam logic [7:0] MASK_MODE = 8'hDF;
  localparam logic [7:0] MASK_OPTION = 8'hCC;
  localparam logic [7:0] MASK_DRV = 8'h5B;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int MODE_ENH = 0;
  localparam int MODE_NONBURST = 1;
  localparam int MODE_IF_LO = 2;
  localparam int MODE_SWAP = 4;
  localparam int MODE_PUSHPULL = 6;
  localparam int MODE_TRISTATE = 7;
  localparam int OPT_DENS_LO = 2;
  localparam int OPT_BOOT_LO = 6;
  localparam int DRV_TYPE_LO = 0;
  localparam int DRV_RATE_LO = 3;
  localparam int DRV_PRECOMP = 6;

  // ==========================================================================
  // Density override codes and AXI responses
  // ==========================================================================
  localparam logic [1:0] DENS_FORCE_ONE = 2'h2;
  localparam logic [1:0] DENS_FORCE_ZERO = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* hw/fdcr_regs.sv */
// Floppy controller configuration register bank with AXI4-Lite slave
`timescale 1ns/1ps

module fdcr_regs
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] core_drive_sel,
  input wire logic [1:0] core_motor_sel,
  input wire logic core_density,
  input wire logic [1:0] pp_drive_sel,
  output logic enhanced_mode,
  output logic dma_non_burst,
  output logic [1:0] interface_variant,
  output logic [1:0] boot_drive,
  output logic [1:0] drive_a_type,
  output logic [1:0] drive_b_type,
  output logic [1:0] drive_type_select0,
  output logic [1:0] drive_type_select1,
  output logic [1:0] data_rate_table_select0,
  output logic [1:0] data_rate_table_select1,
  output logic precomp_disable0,
  output logic precomp_disable1,
  output logic soft_reset_pulse,
  output logic [1:0] drive_sel_o,
  output logic [1:0] drive_sel_oe,
  output logic [1:0] motor_sel_o,
  output logic [1:0] motor_sel_oe,
  output logic density_o,
  output logic density_oe,
  output logic [1:0] pp_drive_sel_o
);

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [7:0] floppy_mode_config;
  logic [7:0] floppy_option_config;
  logic [7:0] drive_type_store;
  logic [7:0] drive_zero_settings;
  logic [7:0] drive_one_settings;
  logic [7:0] soft_reset_count;

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  logic aw_held;
  logic w_held;
  logic [7:0] aw_word;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic [7:0] next_aw_word;
  logic wr_hit;

  // Address and data may come in either order; write fires once both held
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign next_aw_word = s_axi_awaddr[9:2];

  // Capture write address
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held <= 1'b0;
      aw_word <= 8'h00;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_word <= next_aw_word;
      s_axi_awready <= 1'b0;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
    end
    else if (!aw_held && !s_axi_bvalid)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  // Capture write data, low lane only
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end
    else if (do_write)
    begin
      w_held <= 1'b0;
    end
    else if (!w_held && !s_axi_bvalid)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  // Decode which addresses exist on the write side
  always_comb
  begin
    unique case (aw_word)
      fdcr_pkg::IDX_MODE, fdcr_pkg::IDX_OPTION, fdcr_pkg::IDX_TYPE, fdcr_pkg::IDX_RSVD,
      fdcr_pkg::IDX_DRV0, fdcr_pkg::IDX_DRV1, fdcr_pkg::IDX_SOFT_RESET, fdcr_pkg::IDX_STATUS:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fdcr_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? fdcr_pkg::RESP_OKAY : fdcr_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Register updates: only resetn (hard reset) restores defaults
  // ==========================================================================
  logic wr_en;
  assign wr_en = do_write && w_lane0;

  // Configuration registers, reserved bits masked on write
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      floppy_mode_config <= fdcr_pkg::RST_MODE;
      floppy_option_config <= fdcr_pkg::RST_OPTION;
      drive_type_store <= fdcr_pkg::RST_TYPE;
      drive_zero_settings <= fdcr_pkg::RST_DRV;
      drive_one_settings <= fdcr_pkg::RST_DRV;
    end
    else if (wr_en)
    begin
      unique case (aw_word)
        fdcr_pkg::IDX_MODE: floppy_mode_config <= w_byte & fdcr_pkg::MASK_MODE;
        fdcr_pkg::IDX_OPTION: floppy_option_config <= w_byte & fdcr_pkg::MASK_OPTION;
        fdcr_pkg::IDX_TYPE: drive_type_store <= w_byte;
        fdcr_pkg::IDX_DRV0: drive_zero_settings <= w_byte & fdcr_pkg::MASK_DRV;
        fdcr_pkg::IDX_DRV1: drive_one_settings <= w_byte & fdcr_pkg::MASK_DRV;
        default: ;
      endcase
    end
  end

  // Soft reset strobe: pulses the core, never touches the registers above
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      soft_reset_pulse <= 1'b0;
      soft_reset_count <= 8'h00;
    end
    else
    begin
      soft_reset_pulse <= wr_en && (aw_word == fdcr_pkg::IDX_SOFT_RESET) && w_byte[0];
      if (wr_en && (aw_word == fdcr_pkg::IDX_SOFT_RESET) && w_byte[0])
      begin
        soft_reset_count <= soft_reset_count + 8'h01;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  logic [7:0] rd_val;
  logic rd_hit;
  logic [7:0] pin_status;

  // Pin status shows the block's own driven floppy outputs
  assign pin_status = {drive_sel_oe, density_o, density_oe, motor_sel_o, drive_sel_o};

  // Read mux
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr[9:2])
      fdcr_pkg::IDX_MODE: rd_val = floppy_mode_config;
      fdcr_pkg::IDX_OPTION: rd_val = floppy_option_config;
      fdcr_pkg::IDX_TYPE: rd_val = drive_type_store;
      fdcr_pkg::IDX_RSVD: rd_val = 8'h00;
      fdcr_pkg::IDX_DRV0: rd_val = drive_zero_settings;
      fdcr_pkg::IDX_DRV1: rd_val = drive_one_settings;
      fdcr_pkg::IDX_SOFT_RESET: rd_val = soft_reset_count;
      fdcr_pkg::IDX_STATUS: rd_val = pin_status;
      default:
      begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read address accepted when no answer is pending; data one cycle later
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= fdcr_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_hit ? fdcr_pkg::RESP_OKAY : fdcr_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Configuration outputs to the floppy core
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      enhanced_mode <= 1'b0;
      dma_non_burst <= 1'b1;
      interface_variant <= 2'h3;
      boot_drive <= 2'h0;
      drive_a_type <= 2'h3;
      drive_b_type <= 2'h3;
      drive_type_select0 <= 2'h0;
      drive_type_select1 <= 2'h0;
      data_rate_table_select0 <= 2'h0;
      data_rate_table_select1 <= 2'h0;
      precomp_disable0 <= 1'b0;
      precomp_disable1 <= 1'b0;
    end
    else
    begin
      enhanced_mode <= floppy_mode_config[fdcr_pkg::MODE_ENH];
      dma_non_burst <= floppy_mode_config[fdcr_pkg::MODE_NONBURST];
      interface_variant <= floppy_mode_config[fdcr_pkg::MODE_IF_LO +: 2];
      boot_drive <= floppy_option_config[fdcr_pkg::OPT_BOOT_LO +: 2];
      drive_a_type <= drive_type_store[1:0];
      drive_b_type <= drive_type_store[3:2];
      drive_type_select0 <= drive_zero_settings[fdcr_pkg::DRV_TYPE_LO +: 2];
      drive_type_select1 <= drive_one_settings[fdcr_pkg::DRV_TYPE_LO +: 2];
      data_rate_table_select0 <= drive_zero_settings[fdcr_pkg::DRV_RATE_LO +: 2];
      data_rate_table_select1 <= drive_one_settings[fdcr_pkg::DRV_RATE_LO +: 2];
      precomp_disable0 <= drive_zero_settings[fdcr_pkg::DRV_PRECOMP];
      precomp_disable1 <= drive_one_settings[fdcr_pkg::DRV_PRECOMP];
    end
  end

  // ==========================================================================
  // Dedicated floppy pin drivers (active-high select values)
  // ==========================================================================
  logic swap;
  logic push_pull;
  logic tristate;
  logic [1:0] dens_code;
  logic [1:0] next_drive_sel;
  logic [1:0] next_motor_sel;
  logic next_density;

  assign swap = floppy_mode_config[fdcr_pkg::MODE_SWAP];
  assign push_pull = floppy_mode_config[fdcr_pkg::MODE_PUSHPULL];
  assign tristate = floppy_mode_config[fdcr_pkg::MODE_TRISTATE];
  assign dens_code = floppy_option_config[fdcr_pkg::OPT_DENS_LO +: 2];

  // Swap and density override
  always_comb
  begin
    next_drive_sel = swap ? {core_drive_sel[0], core_drive_sel[1]} : core_drive_sel;
    next_motor_sel = swap ? {core_motor_sel[0], core_motor_sel[1]} : core_motor_sel;
    if (dens_code == fdcr_pkg::DENS_FORCE_ONE)
    begin
      next_density = 1'b1;
    end
    else if (dens_code == fdcr_pkg::DENS_FORCE_ZERO)
    begin
      next_density = 1'b0;
    end
    else
    begin
      next_density = core_density;
    end
  end

  // Pin value and enable: open drain drives only low, tristate drives nothing
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      drive_sel_o <= 2'h0;
      drive_sel_oe <= 2'h0;
      motor_sel_o <= 2'h0;
      motor_sel_oe <= 2'h0;
      density_o <= 1'b0;
      density_oe <= 1'b0;
    end
    else
    begin
      drive_sel_o <= next_drive_sel;
      motor_sel_o <= next_motor_sel;
      density_o <= next_density;
      drive_sel_oe <= tristate ? 2'h0 : (push_pull ? 2'h3 : ~next_drive_sel);
      motor_sel_oe <= tristate ? 2'h0 : (push_pull ? 2'h3 : ~next_motor_sel);
      density_oe <= tristate ? 1'b0 : (push_pull | ~next_density);
    end
  end

  // Parallel-port floppy path ignores style and tristate controls
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pp_drive_sel_o <= 2'h0;
    end
    else
    begin
      pp_drive_sel_o <= swap ? {pp_drive_sel[0], pp_drive_sel[1]} : pp_drive_sel;
    end
  end

endmodule

/* test/fdcr_regs_chk.sv */
// Port checker for the floppy configuration register bank
`timescale 1ns/1ps
module fdcr_regs_chk
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] core_drive_sel,
  input wire logic [1:0] core_motor_sel,
  input wire logic [1:0] pp_drive_sel,
  input wire logic enhanced_mode,
  input wire logic dma_non_burst,
  input wire logic [1:0] interface_variant,
  input wire logic [1:0] drive_a_type,
  input wire logic soft_reset_pulse,
  input wire logic [1:0] drive_sel_o,
  input wire logic [1:0] drive_sel_oe,
  input wire logic [1:0] motor_sel_o,
  input wire logic [1:0] motor_sel_oe,
  input wire logic density_o,
  input wire logic density_oe,
  input wire logic [1:0] pp_drive_sel_o
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ==========================================================================
  // Register reads
  // Request to the read-as-zero index, then its answer
  sequence s_rsvd_req;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {fdcr_pkg::IDX_RSVD, 2'b00};
  endsequence
  sequence s_zero_ans;
    s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == fdcr_pkg::RESP_OKAY;
  endsequence
  property p_rsvd_zero;
    s_rsvd_req |=> s_zero_ans;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved index read not zero");
  property p_upper_zero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

  // ==========================================================================
  // Reset and soft reset
  property p_defaults;
    $rose(resetn) |-> dma_non_burst && !enhanced_mode && interface_variant == 2'h3 && drive_a_type == 2'h3;
  endproperty
  a_defaults: assert property (p_defaults) else $error("outputs not at defaults after reset");
  // Configuration outputs stay put across the soft reset
  sequence s_keep;
    ($stable(interface_variant) && $stable(dma_non_burst) && $stable(drive_a_type)) [*3];
  endsequence
  property p_soft;
    soft_reset_pulse |=> s_keep;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset changed configuration");
  // Soft reset strobe lasts a single cycle
  property p_pulse_once;
    soft_reset_pulse |=> !soft_reset_pulse;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("soft reset pulse longer than one cycle");

  // ==========================================================================
  // Pins
  property p_swap;
    $past(resetn) |-> (drive_sel_o == $past(core_drive_sel) && motor_sel_o == $past(core_motor_sel)) ||
      (drive_sel_o == {$past(core_drive_sel[0]), $past(core_drive_sel[1])} &&
      motor_sel_o == {$past(core_motor_sel[0]), $past(core_motor_sel[1])});
  endproperty
  a_swap: assert property (p_swap) else $error("drive and motor selects not swapped together");
  property p_pp_free;
    $past(resetn) |-> pp_drive_sel_o == $past(pp_drive_sel) ||
      pp_drive_sel_o == {$past(pp_drive_sel[0]), $past(pp_drive_sel[1])};
  endproperty
  a_pp_free: assert property (p_pp_free) else $error("parallel select path altered");
  property p_style;
    ({drive_sel_oe, density_oe} == {~drive_sel_o, !density_o}) || {drive_sel_oe, motor_sel_oe, density_oe} == 5'h1F ||
      {drive_sel_oe, motor_sel_oe, density_oe} == 5'h00;
  endproperty
  a_style: assert property (p_style) else $error("output enables fit no drive style");
  property p_tri;
    !density_oe && !density_o |-> drive_sel_oe == 2'h0 && motor_sel_oe == 2'h0;
  endproperty
  a_tri: assert property (p_tri) else $error("outputs driven while tristated");
endmodule

bind fdcr_regs fdcr_regs_chk i_chk (.clk(clk), .resetn(resetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .core_drive_sel(core_drive_sel),
  .core_motor_sel(core_motor_sel), .pp_drive_sel(pp_drive_sel), .enhanced_mode(enhanced_mode),
  .dma_non_burst(dma_non_burst), .interface_variant(interface_variant), .drive_a_type(drive_a_type),
  .soft_reset_pulse(soft_reset_pulse), .drive_sel_o(drive_sel_o), .drive_sel_oe(drive_sel_oe),
  .motor_sel_o(motor_sel_o), .motor_sel_oe(motor_sel_oe), .density_o(density_o), .density_oe(density_oe),
  .pp_drive_sel_o(pp_drive_sel_o));

/* test/fdcr_core_model.sv */
// Floppy core stand-in driving drive, motor and density selections
`timescale 1ns/1ps
module fdcr_core_model
(
  input wire logic clk,
  input wire logic drv,
  input wire logic dens,
  output logic [1:0] drive_sel,
  output logic [1:0] motor_sel,
  output logic density,
  output logic [1:0] pp_sel
);
  // One-hot selection of the chosen drive, updated just after the edge
  always_ff @(posedge clk)
  begin
    drive_sel <= drv ? 2'h2 : 2'h1;
    motor_sel <= drv ? 2'h2 : 2'h1;
    density <= dens;
    pp_sel <= drv ? 2'h2 : 2'h1;
  end
endmodule

/* test/fdcr_regs_tb.sv */
// Self-checking bench for the floppy configuration register bank
`timescale 1ns/1ps
module fdcr_regs_tb;
  // ==========================================================================
  // Signals
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic drv = 1'b0;
  logic dens = 1'b0;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, wresp, core_drive_sel, core_motor_sel, pp_drive_sel, interface_variant;
  logic [1:0] boot_drive, drive_a_type, drive_b_type, drive_type_select0, drive_type_select1;
  logic [1:0] data_rate_table_select0, data_rate_table_select1, drive_sel_o, drive_sel_oe, motor_sel_o;
  logic [1:0] motor_sel_oe, pp_drive_sel_o;
  logic core_density, enhanced_mode, dma_non_burst, precomp_disable0, precomp_disable1, soft_reset_pulse;
  logic density_o, density_oe;
  int compares = 0;
  int miscompares = 0;

  // Design and floppy core stand-in
  fdcr_regs i_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .core_drive_sel(core_drive_sel), .core_motor_sel(core_motor_sel), .core_density(core_density),
    .pp_drive_sel(pp_drive_sel), .enhanced_mode(enhanced_mode), .dma_non_burst(dma_non_burst),
    .interface_variant(interface_variant), .boot_drive(boot_drive), .drive_a_type(drive_a_type),
    .drive_b_type(drive_b_type), .drive_type_select0(drive_type_select0), .drive_type_select1(drive_type_select1),
    .data_rate_table_select0(data_rate_table_select0), .data_rate_table_select1(data_rate_table_select1),
    .precomp_disable0(precomp_disable0), .precomp_disable1(precomp_disable1), .soft_reset_pulse(soft_reset_pulse),
    .drive_sel_o(drive_sel_o), .drive_sel_oe(drive_sel_oe), .motor_sel_o(motor_sel_o), .motor_sel_oe(motor_sel_oe),
    .density_o(density_o), .density_oe(density_oe), .pp_drive_sel_o(pp_drive_sel_o));
  fdcr_core_model i_core (.clk(clk), .drv(drv), .dens(dens), .drive_sel(core_drive_sel), .motor_sel(core_motor_sel),
    .density(core_density), .pp_sel(pp_drive_sel));

  // 250 MHz clock
  always #2 clk = ~clk;

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Write one register by index; address and data offered together
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge clk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    wresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Read one register by index and compare data and response
  task automatic rc(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, e});
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  task automatic wrap_up;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rc(fdcr_pkg::IDX_MODE, 8'h0E, fdcr_pkg::RESP_OKAY);
    rc(fdcr_pkg::IDX_OPTION, 8'h00, fdcr_pkg::RESP_OKAY);
    rc(fdcr_pkg::IDX_TYPE, 8'hFF, fdcr_pkg::RESP_OKAY);
    rc(fdcr_pkg::IDX_DRV1, 8'h00, fdcr_pkg::RESP_OKAY);
    chk(32'({precomp_disable0, precomp_disable1, boot_drive, drive_b_type}), 32'h3);
    rc(8'h10, 8'h00, fdcr_pkg::RESP_SLVERR);
    wr(fdcr_pkg::IDX_MODE, 8'hDF);
    wr(fdcr_pkg::IDX_RSVD, 8'hFF);
    chk(32'(wresp), 32'(fdcr_pkg::RESP_OKAY));
    wr(fdcr_pkg::IDX_DRV0, 8'hFF);
    wr(fdcr_pkg::IDX_DRV1, 8'h4A);
    wr(fdcr_pkg::IDX_TYPE, 8'h09);
    // Low byte lane not strobed: the write is answered but stores nothing
    s_axi_wstrb <= 4'hE;
    wr(fdcr_pkg::IDX_TYPE, 8'h00);
    s_axi_wstrb <= 4'hF;
    chk(32'(wresp), 32'(fdcr_pkg::RESP_OKAY));
    wr(8'h10, 8'hFF);
    chk(32'(wresp), 32'(fdcr_pkg::RESP_SLVERR));
    rc(fdcr_pkg::IDX_MODE, 8'hDF, fdcr_pkg::RESP_OKAY);
    rc(fdcr_pkg::IDX_RSVD, 8'h00, fdcr_pkg::RESP_OKAY);
    rc(fdcr_pkg::IDX_DRV0, 8'h5B, fdcr_pkg::RESP_OKAY);
    rc(fdcr_pkg::IDX_DRV1, 8'h4A, fdcr_pkg::RESP_OKAY);
    chk(32'({enhanced_mode, dma_non_burst, interface_variant}), 32'hF);
    chk(32'({drive_type_select0, data_rate_table_select0, precomp_disable0}), 32'h1F);
    chk(32'({drive_type_select1, data_rate_table_select1, precomp_disable1}), 32'h13);
    chk(32'({drive_b_type, drive_a_type}), 32'h9);
    chk(32'({drive_sel_oe, motor_sel_oe, density_oe}), 32'h0);
    chk(32'({drive_sel_o, motor_sel_o, pp_drive_sel_o}), 32'h2A);
    wr(fdcr_pkg::IDX_MODE, 8'h44);
    chk(32'({enhanced_mode, dma_non_burst, interface_variant}), 32'h1);
    chk(32'({drive_sel_o, drive_sel_oe, motor_sel_oe}), 32'h1F);
    drv <= 1'b1;
    wr(fdcr_pkg::IDX_MODE, 8'h00);
    chk(32'({interface_variant, drive_sel_o, drive_sel_oe}), 32'h09);
    wr(fdcr_pkg::IDX_OPTION, 8'h48);
    chk(32'({density_o, boot_drive}), 32'h5);
    dens <= 1'b1;
    wr(fdcr_pkg::IDX_OPTION, 8'hCC);
    chk(32'({density_o, boot_drive}), 32'h3);
    wr(fdcr_pkg::IDX_OPTION, 8'h84);
    chk(32'({density_o, boot_drive}), 32'h6);
    // Open drain, no swap, drive 1 selected, density high and undriven
    rc(fdcr_pkg::IDX_STATUS, 8'h6A, fdcr_pkg::RESP_OKAY);
    wr(fdcr_pkg::IDX_SOFT_RESET, 8'h01);
    rc(fdcr_pkg::IDX_SOFT_RESET, 8'h01, fdcr_pkg::RESP_OKAY);
    rc(fdcr_pkg::IDX_OPTION, 8'h84, fdcr_pkg::RESP_OKAY);
    rc(fdcr_pkg::IDX_DRV1, 8'h4A, fdcr_pkg::RESP_OKAY);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rc(fdcr_pkg::IDX_MODE, 8'h0E, fdcr_pkg::RESP_OKAY);
    rc(fdcr_pkg::IDX_TYPE, 8'hFF, fdcr_pkg::RESP_OKAY);
    rc(fdcr_pkg::IDX_DRV1, 8'h00, fdcr_pkg::RESP_OKAY);
    rc(fdcr_pkg::IDX_SOFT_RESET, 8'h00, fdcr_pkg::RESP_OKAY);
    wrap_up();
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule
